// [bench/rmp_mp_checker.sv]
// rmp_mp_checker: assertions on the micro port between the master device and its controller
`timescale 1ns/1ps
`default_nettype none
module rmp_mp_checker
    import rmp_pkg::*;
(
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);
    ////////////////////////////////////////////////////////////////////////
    sequence s_src_read;
        rd && addr == A_SRC;
    endsequence
    sequence s_remote_write;
        wr && addr == A_REMOTE;
    endsequence
    sequence s_bits_write;
        wr && addr == A_BITS;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    a_rdata_idle_zero: assert property (!rd |=> rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    a_strobe_excl: assert property (!(wr && rd))
        else $error("read and write strobes together");
    a_read_single: assert property (rd |=> !rd)
        else $error("read strobe longer than one cycle");
    a_src_then_remote: assert property (s_src_read |-> ##[1:4] s_remote_write)
        else $error("source read not followed by remote mask write");
    a_remote_cause: assert property (s_remote_write |-> $past(rd && addr == A_SRC, 2))
        else $error("remote mask written without a source read");
    a_bits_cause: assert property (s_bits_write |->
        ($past(rd && addr == A_BITS, 2) || $past(rd && addr == A_BITS, 3)))
        else $error("bits group written without reading it first");
    a_bits_range: assert property (s_bits_write |-> wdata[7:3] == 5'h00)
        else $error("bits group index out of range");
    a_read_map: assert property (rd |-> (addr == A_SRC || addr == A_BITS))
        else $error("controller read of an unexpected address");
    a_cmd_code: assert property (wr && addr == A_CMD |->
        wdata[7:2] == 6'h00 && wdata[1:0] != 2'h0)
        else $error("command write with no or unknown command");
    c_mirror: cover property (s_src_read ##[1:4] s_remote_write);
endmodule
`default_nettype wire

// [bench/test_redundancy_master_slave_protection.sv]
// test_redundancy_master_slave_protection: two devices and two controllers in a protected pair
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
`define WAIT_FOR(c) begin w = 0; while (!(c) && w < 600) begin @(negedge clk_i); w++; end end
module test_redundancy_master_slave_protection;
    import rmp_pkg::*;
    localparam int FCYC = 40;
    logic clk_i, nrst_i, nrst_b;
    logic [7:0] ref_a, ref_b, own_a, own_b;
    logic [1:0] psel, penable, pwrite, rdy, serr;
    logic [11:0] paddr [2];
    logic [31:0] pwdata [2];
    logic [31:0] prd [2];
    logic [31:0] rd_q;
    logic rd_e, frame_a, frame_b, mf_a, mf_b, act_a, act_b, hold_a, hold_b;
    logic [SELW-1:0] sel_a, sel_b, bits_a, bits_b;
    int mismatches = 0, tests_run = 0, w, eq, hf, hm;
    ////////////////////////////////////////////////////////////////////////
    rmp_mp_if mp_a();
    rmp_mp_if mp_b();
    // multiframe sync lines cross connected as on the board
    rmp_dev #(.NREF(8), .FRAME_CYC(FCYC)) u_rmp_dev_a (.clk_i(clk_i), .nrst_i(nrst_i),
        .mp(mp_a), .ref_valid_i(ref_a), .ext_multiframe_sync_input_i(mf_b),
        .frame_clk_o(frame_a), .mf_clk_o(mf_a), .sel_ref_o(sel_a),
        .bits_feed_output_group_sel_o(bits_a), .active_o(act_a), .holdover_o(hold_a));
    rmp_dev #(.NREF(8), .FRAME_CYC(FCYC)) u_rmp_dev_b (.clk_i(clk_i), .nrst_i(nrst_b),
        .mp(mp_b), .ref_valid_i(ref_b), .ext_multiframe_sync_input_i(mf_a),
        .frame_clk_o(frame_b), .mf_clk_o(mf_b), .sel_ref_o(sel_b),
        .bits_feed_output_group_sel_o(bits_b), .active_o(act_b), .holdover_o(hold_b));
    rmp_ctl u_rmp_ctl_a (.clk_i(clk_i), .nrst_i(nrst_i), .mp(mp_a), .psel(psel[0]),
        .penable(penable[0]), .pwrite(pwrite[0]), .paddr(paddr[0]), .pwdata(pwdata[0]),
        .prdata(prd[0]), .pready(rdy[0]), .pslverr(serr[0]),
        .partner_sources_i(own_b), .own_sources_o(own_a));
    rmp_ctl u_rmp_ctl_b (.clk_i(clk_i), .nrst_i(nrst_i), .mp(mp_b), .psel(psel[1]),
        .penable(penable[1]), .pwrite(pwrite[1]), .paddr(paddr[1]), .pwdata(pwdata[1]),
        .prdata(prd[1]), .pready(rdy[1]), .pslverr(serr[1]),
        .partner_sources_i(own_a), .own_sources_o(own_b));
    rmp_mp_checker u_chk (.clk_i(clk_i), .nrst_i(nrst_i), .addr(mp_a.addr), .wr(mp_a.wr),
        .rd(mp_a.rd), .wdata(mp_a.wdata), .rdata(mp_a.rdata));
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    // one apb transfer on controller k; waits up to 50 cycles for pready
    task automatic apb(input int k, input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        psel[k] <= 1'b1;
        penable[k] <= 1'b0;
        pwrite[k] <= wr;
        paddr[k] <= a;
        pwdata[k] <= d;
        @(posedge clk_i);
        penable[k] <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (rdy[k] !== 1'b1 && n < 50);
        rd_q = prd[k];
        rd_e = serr[k];
        psel[k] <= 1'b0;
        penable[k] <= 1'b0;
    endtask
    task automatic refs(input logic [7:0] a, input logic [7:0] b);
        @(posedge clk_i);
        ref_a <= a;
        ref_b <= b;
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        apb(0, 1'b0, P_MODE, 32'h0);
        `CHK("mode reset", 32'h00000000, rd_q)
        apb(0, 1'b0, 12'h0FC, 32'h0);
        `CHK("unmapped error", 1'b1, rd_e)
        `CHK("unmapped data", 32'h00000000, rd_q)
    endtask
    task automatic t_roles();
        refs(8'h06, 8'h07);
        apb(0, 1'b1, P_MODE, 32'h0000000A);
        apb(1, 1'b1, P_MODE, 32'h00000008);
        apb(0, 1'b1, P_CTL, 32'h00000001);
        apb(1, 1'b1, P_CTL, 32'h00000001);
        `WAIT_FOR(sel_a === 3'h1 && act_b === 1'b0 && bits_a === 3'h1)
        `CHK("master sel", 3'h1, sel_a)
        `CHK("slave tracks", 1'b0, act_b)
        `CHK("slave sel", 3'h0, sel_b)
        `CHK("bits group", 3'h1, bits_a)
        apb(0, 1'b0, P_MODE, 32'h0);
        `CHK("mode read", 32'h0000000A, rd_q)
    endtask
    task automatic t_masks();
        refs(8'h06, 8'h05);
        `WAIT_FOR(sel_a === 3'h2)
        `CHK("remote mask", 3'h2, sel_a)
        refs(8'h04, 8'h05);
        `WAIT_FOR(bits_a === 3'h2)
        `CHK("shared loss sel", 3'h2, sel_a)
        `CHK("bits moved", 3'h2, bits_a)
        `CHK("slave still tracks", 1'b0, act_b)
        refs(8'h06, 8'h07);
        `WAIT_FOR(sel_a === 3'h1)
        `CHK("local mask", 3'h1, sel_a)
    endtask
    task automatic t_frames();
        eq = 0;
        repeat (4 * FCYC) begin
            @(negedge clk_i);
            if (frame_a === frame_b && mf_a === mf_b) eq++;
        end
        `CHK("aligned cycles", 4 * FCYC, eq)
    endtask
    task automatic t_failover();
        refs(8'h06, 8'h06);
        `WAIT_FOR(act_b === 1'b1 && sel_b === 3'h1)
        `CHK("slave active", 1'b1, act_b)
        `CHK("slave takes table", 3'h1, sel_b)
        refs(8'h00, 8'h00);
        `WAIT_FOR(hold_b === 1'b1)
        `CHK("slave holdover", 1'b1, hold_b)
        refs(8'h06, 8'h07);
        `WAIT_FOR(act_b === 1'b0)
    endtask
    task automatic t_subordinate();
        apb(0, 1'b1, P_CTL, 32'h00000005);
        `WAIT_FOR(act_a === 1'b0)
        // two multiframes give the sync edges time to mark alignment
        repeat (8 * FCYC) @(negedge clk_i);
        `CHK("stays subordinate", 1'b0, act_a)
        apb(0, 1'b1, P_CTL, 32'h00000003);
        `WAIT_FOR(act_a === 1'b1)
        `CHK("switched back", 1'b1, act_a)
    endtask
    task automatic t_freerun();
        apb(1, 1'b1, P_MODE, 32'h00000000);
        // restart the far end off phase; the near end must pull back to its sync
        @(posedge frame_a);
        repeat (7) @(posedge clk_i);
        nrst_b <= 1'b0;
        repeat (3) @(posedge clk_i);
        nrst_b <= 1'b1;
        repeat (8 * FCYC) @(negedge clk_i);
        eq = 0;
        hf = 0;
        hm = 0;
        repeat (4 * FCYC) begin
            @(negedge clk_i);
            if (frame_a === frame_b && mf_a === mf_b) eq++;
            hf += int'(frame_b === 1'b1);
            hm += int'(mf_b === 1'b1);
        end
        `CHK("realigned cycles", 4 * FCYC, eq)
        `CHK("free frame duty", 2 * FCYC, hf)
        `CHK("free multiframe duty", 2 * FCYC, hm)
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        nrst_i = 1'b0;
        nrst_b = 1'b0;
        ref_a = 8'h00;
        ref_b = 8'h00;
        psel = 2'b00;
        penable = 2'b00;
        pwrite = 2'b00;
        paddr = '{12'h000, 12'h000};
        pwdata = '{32'h0, 32'h0};
        repeat (4) @(negedge clk_i);
        `CHK("reset frame", 1'b1, frame_a)
        `CHK("reset active", 1'b1, act_a)
        `CHK("reset hold", 1'b0, hold_a)
        @(posedge clk_i);
        nrst_i <= 1'b1;
        nrst_b <= 1'b1;
        t_reset();
        t_roles();
        t_masks();
        t_frames();
        t_failover();
        t_subordinate();
        t_freerun();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        mismatches++;
        report_and_stop();
    end
endmodule
`default_nettype wire

// [verilog/rmp_ctl.sv]
// rmp_ctl: controller end, APB registers and the table mirroring sequencer
`timescale 1ns/1ps
`default_nettype none
module rmp_ctl (
    input wire logic clk_i,
    input wire logic nrst_i,
    rmp_mp_if.ctl mp,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] partner_sources_i,
    output logic [7:0] own_sources_o
);
    import rmp_pkg::*;

    rmp_cstate_t st;
    rmp_cstate_t next_st;
    logic mirror_en;
    logic [7:0] mode_val;
    logic mode_dirty;
    logic [1:0] cmd_pend;
    logic [7:0] src_q;
    logic [7:0] bits_q;
    logic [7:0] addr_q;
    logic wr_q;
    logic rd_q;
    logic [7:0] wdata_q;
    logic [31:0] prdata_q;
    logic next_mirror_en;
    logic [7:0] next_mode_val;
    logic next_mode_dirty;
    logic [1:0] next_cmd_pend;
    logic [7:0] next_src_q;
    logic [7:0] next_bits_q;
    logic [7:0] next_addr;
    logic next_wr;
    logic next_rd;
    logic [7:0] next_wdata;
    logic [31:0] next_prdata;
    logic apb_wr;
    logic apb_rd;
    logic mapped;
    logic [3:0] pk;

    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;
    assign mapped = paddr == P_CTL || paddr == P_MODE || paddr == P_STAT;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign pk = rmp_pick(src_q);

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        next_st = st;
        next_mirror_en = mirror_en;
        next_mode_val = mode_val;
        next_mode_dirty = mode_dirty;
        next_cmd_pend = cmd_pend;
        next_src_q = src_q;
        next_bits_q = bits_q;
        next_addr = addr_q;
        next_wdata = wdata_q;
        next_wr = 1'b0;
        next_rd = 1'b0;
        next_prdata = prdata_q;
        case (st)
            CS_IDLE: begin
                if (mode_dirty) begin
                    next_wr = 1'b1;
                    next_addr = A_MODE;
                    next_wdata = mode_val;
                    next_mode_dirty = 1'b0;
                end else if (cmd_pend != 2'b00) begin
                    next_wr = 1'b1;
                    next_addr = A_CMD;
                    next_wdata = {6'h00, cmd_pend};
                    next_cmd_pend = 2'b00;
                end else if (mirror_en) begin
                    next_rd = 1'b1;
                    next_addr = A_SRC;
                    next_st = CS_RS_W;
                end
            end
            CS_RS_W: next_st = CS_RS_C;
            CS_RS_C: begin
                next_src_q = mp.rdata;
                // partner view becomes this device's remote mask
                next_wr = 1'b1; // [RULE5]
                next_addr = A_REMOTE;
                next_wdata = partner_sources_i;
                next_st = CS_RB;
            end
            CS_RB: begin
                next_rd = 1'b1;
                next_addr = A_BITS;
                next_st = CS_RB_W;
            end
            CS_RB_W: next_st = CS_RB_C;
            CS_RB_C: begin
                next_bits_q = mp.rdata;
                // that group has no holdover, so move it at once
                if (!src_q[mp.rdata[2:0]] && pk[3]) begin
                    next_wr = 1'b1; // [RULE12]
                    next_addr = A_BITS;
                    next_wdata = {5'h00, pk[2:0]};
                end
                next_st = CS_IDLE;
            end
            default: next_st = CS_IDLE;
        endcase
        // software requests win over the sequencer clearing them
        if (apb_wr && paddr == P_CTL) begin
            next_mirror_en = pwdata[CTL_MIRROR];
            if (pwdata[CTL_SWBACK]) begin
                next_cmd_pend[CMD_SWBACK] = 1'b1;
            end
            if (pwdata[CTL_SUB]) begin
                next_cmd_pend[CMD_SUB] = 1'b1;
            end
        end else if (apb_wr && paddr == P_MODE) begin
            next_mode_val = pwdata[7:0];
            next_mode_dirty = 1'b1;
        end
        if (apb_rd) begin
            if (paddr == P_CTL) begin
                next_prdata = {31'h0, mirror_en};
            end else if (paddr == P_MODE) begin
                next_prdata = {24'h0, mode_val};
            end else if (paddr == P_STAT) begin
                next_prdata = {15'h0, st != CS_IDLE, bits_q, src_q};
            end else begin
                next_prdata = 32'h0;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st <= CS_IDLE;
            mirror_en <= 1'b0;
            mode_val <= MODE_RST;
            mode_dirty <= 1'b0;
            cmd_pend <= 2'b00;
            src_q <= 8'h00;
            bits_q <= 8'h00;
            addr_q <= 8'h00;
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            wdata_q <= 8'h00;
            prdata_q <= 32'h0;
        end else begin
            st <= next_st;
            mirror_en <= next_mirror_en;
            mode_val <= next_mode_val;
            mode_dirty <= next_mode_dirty;
            cmd_pend <= next_cmd_pend;
            src_q <= next_src_q;
            bits_q <= next_bits_q;
            addr_q <= next_addr;
            wr_q <= next_wr;
            rd_q <= next_rd;
            wdata_q <= next_wdata;
            prdata_q <= next_prdata;
        end
    end

    assign mp.addr = addr_q;
    assign mp.wr = wr_q;
    assign mp.rd = rd_q;
    assign mp.wdata = wdata_q;
    assign prdata = prdata_q;
    assign own_sources_o = src_q; // [RULE5]
endmodule
`default_nettype wire

// [verilog/rmp_dev.sv]
// rmp_dev: redundancy protection logic of one timing device
// What the protection scheme requires of device, controller and board
// [RULE1] frame and multiframe clocks aligned within one cycle
// [RULE2] role taken from mode register bit 1
// [RULE3] local valid sources mask the table
// [RULE4] remote valid register also masks the table
// [RULE5] controller copies sources between the two devices
// [RULE6] slave prefers master clock input, else same order
// [RULE7] slave locks and stays on first input
// [RULE8] slave enters holdover when nothing valid remains
// [RULE9] slave takes over clocks, table and switching
// [RULE10] replaced master subordinate until aligned and switched back
// [RULE11] shared source failure updates both tables alike
// [RULE12] controller moves bits feed group on failure
// [RULE13] board cross connects the multiframe sync lines
// [RULE14] sync alignment only while mode bit 3 set
// [RULE15] free running frame clocks while sync disabled
`timescale 1ns/1ps
`default_nettype none
module rmp_dev #(
    parameter int NREF = 8,
    parameter int FRAME_CYC = rmp_pkg::FRAME_CYC
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    rmp_mp_if.dev mp,
    input wire logic [NREF-1:0] ref_valid_i,
    input wire logic ext_multiframe_sync_input_i,
    output logic frame_clk_o,
    output logic mf_clk_o,
    output logic [rmp_pkg::SELW-1:0] sel_ref_o,
    output logic [rmp_pkg::SELW-1:0] bits_feed_output_group_sel_o,
    output logic active_o,
    output logic holdover_o
);
    import rmp_pkg::*;

    localparam int CW = $clog2(FRAME_CYC);

    generate
        if (NREF < 2 || NREF > 8) begin : g_bad_nref
            $error("rmp_dev: NREF must be 2 to 8");
        end
        if (FRAME_CYC < 8 || (FRAME_CYC % 2) != 0) begin : g_bad_frame
            $error("rmp_dev: FRAME_CYC must be even and at least 8");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [NREF-1:0] ref_s1;
    logic [NREF-1:0] ref_s2;
    logic sy_s1;
    logic sy_s2;
    logic sy_s3;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ref_s1 <= '0;
            ref_s2 <= '0;
            sy_s1 <= 1'b0;
            sy_s2 <= 1'b0;
            sy_s3 <= 1'b0;
        end else begin
            ref_s1 <= ref_valid_i;
            ref_s2 <= ref_s1;
            sy_s1 <= ext_multiframe_sync_input_i;
            sy_s2 <= sy_s1;
            sy_s3 <= sy_s2;
        end
    end

    logic sy_rise;
    assign sy_rise = sy_s2 & ~sy_s3;

    ////////////////////////////////////////////////////////////////////////
    // microprocessor port registers
    logic [7:0] mode;
    logic [7:0] remote;
    logic [7:0] bits_sel;
    logic [7:0] rdata;
    logic table_ok;
    logic [7:0] next_mode;
    logic [7:0] next_remote;
    logic [7:0] next_bits_sel;
    logic [7:0] next_rdata;
    logic next_table_ok;
    logic cmd_swback;
    logic cmd_sub;
    logic is_master;
    logic [7:0] stat;
    logic [7:0] local_src;

    assign local_src = 8'(ref_s2);
    assign is_master = mode[MODE_MASTER]; // [RULE2]
    assign cmd_swback = mp.wr && mp.addr == A_CMD && mp.wdata[CMD_SWBACK];
    assign cmd_sub = mp.wr && mp.addr == A_CMD && mp.wdata[CMD_SUB];

    always_comb begin
        next_mode = mode;
        next_remote = remote;
        next_bits_sel = bits_sel;
        next_table_ok = table_ok;
        next_rdata = 8'h00;
        if (cmd_sub) begin
            next_table_ok = 1'b0;
        end
        if (mp.wr) begin
            if (mp.addr == A_MODE) begin
                next_mode = mp.wdata;
            end else if (mp.addr == A_REMOTE) begin
                next_remote = mp.wdata; // [RULE4]
                // the load that proves table alignment wins over a clear
                next_table_ok = 1'b1; // [RULE10]
            end else if (mp.addr == A_BITS) begin
                next_bits_sel = mp.wdata;
            end
        end
        if (mp.rd) begin
            if (mp.addr == A_SRC) begin
                next_rdata = local_src; // [RULE3]
            end else if (mp.addr == A_REMOTE) begin
                next_rdata = remote;
            end else if (mp.addr == A_STAT) begin
                next_rdata = stat;
            end else if (mp.addr == A_BITS) begin
                next_rdata = bits_sel;
            end else if (mp.addr == A_MODE) begin
                next_rdata = mode;
            end else begin
                next_rdata = 8'h00;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode <= MODE_RST;
            remote <= REMOTE_RST;
            bits_sel <= BITS_RST;
            rdata <= 8'h00;
            table_ok <= 1'b0;
        end else begin
            mode <= next_mode;
            remote <= next_remote;
            bits_sel <= next_bits_sel;
            rdata <= next_rdata;
            table_ok <= next_table_ok;
        end
    end

    assign mp.rdata = rdata;

    ////////////////////////////////////////////////////////////////////////
    // frame and multiframe generation
    logic [CW-1:0] cnt;
    logic [1:0] mfc;
    logic aligned;
    logic frame_q;
    logic mf_q;
    logic [CW-1:0] next_cnt;
    logic [1:0] next_mfc;
    logic next_aligned;
    logic next_frame;
    logic next_mf;
    logic at_target;

    // the sync edge is seen SYNC_LAT - 1 edges late, so expect the count there
    assign at_target = cnt == CW'(SYNC_LAT - 1) && mfc == 2'd0;

    always_comb begin
        next_aligned = aligned;
        next_mfc = mfc;
        if (cnt == CW'(FRAME_CYC - 1)) begin
            next_cnt = '0;
            next_mfc = (mfc == 2'(MF_FRAMES - 1)) ? 2'd0 : mfc + 2'd1;
        end else begin
            next_cnt = cnt + CW'(1);
        end
        if (cmd_sub) begin
            next_aligned = 1'b0;
        end
        if (mode[MODE_EXTSYNC] && sy_rise) begin // [RULE14] [RULE13]
            // reload so both ends see their edges on the same cycle
            next_cnt = CW'(SYNC_LAT); // [RULE1]
            next_mfc = 2'd0;
            next_aligned = at_target;
        end else if (!mode[MODE_EXTSYNC]) begin
            next_aligned = 1'b0; // [RULE15]
        end
        next_frame = next_cnt < CW'(FRAME_CYC / 2);
        next_mf = next_mfc < 2'(MF_FRAMES / 2);
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cnt <= '0;
            mfc <= 2'd0;
            aligned <= 1'b0;
            frame_q <= 1'b1;
            mf_q <= 1'b1;
        end else begin
            cnt <= next_cnt;
            mfc <= next_mfc;
            aligned <= next_aligned;
            frame_q <= next_frame;
            mf_q <= next_mf;
        end
    end

    assign frame_clk_o = frame_q;
    assign mf_clk_o = mf_q;

    ////////////////////////////////////////////////////////////////////////
    // role and reference selection
    rmp_dstate_t st;
    rmp_dstate_t next_st;
    logic [SELW-1:0] sel;
    logic [SELW-1:0] next_sel;
    logic [7:0] mask;
    logic [3:0] pk;
    logic [7:0] own_mask;

    // same masks on both devices give the same table after a shared failure
    assign mask = local_src & remote; // [RULE3] [RULE4] [RULE11]
    // slave order skips input 0, which carries the master clock
    assign own_mask = is_master ? mask : (mask & 8'hFE); // [RULE6]
    assign pk = rmp_pick(own_mask);

    always_comb begin
        next_st = st;
        next_sel = sel;
        if (st == DS_SUB && !(cmd_swback && aligned && table_ok)) begin
            // keeps tracking the table, but never drives the pair
            next_st = DS_SUB; // [RULE10]
            if (pk[3]) begin
                next_sel = pk[SELW-1:0];
            end
        end else if (is_master && cmd_sub) begin
            next_st = DS_SUB; // [RULE10]
        end else if (!is_master && local_src[0]) begin
            next_st = DS_TRACK; // [RULE7] [RULE6]
            next_sel = '0;
        end else if (pk[3]) begin
            next_st = DS_LOCKED; // [RULE9]
            next_sel = pk[SELW-1:0];
        end else begin
            case (st)
                DS_FREE: next_st = DS_FREE;
                default: next_st = DS_HOLD; // [RULE8]
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st <= DS_FREE;
            sel <= '0;
        end else begin
            st <= next_st;
            sel <= next_sel;
        end
    end

    // a slave tracking the master only stands by
    assign active_o = (st != DS_SUB) && (st != DS_TRACK); // [RULE9]
    assign holdover_o = st == DS_HOLD;
    assign sel_ref_o = sel;
    assign bits_feed_output_group_sel_o = bits_sel[SELW-1:0];
    assign stat = {active_o, holdover_o, aligned, table_ok, 1'b0, 3'(sel)};
endmodule
`default_nettype wire

// [verilog/rmp_mp_if.sv]
// rmp_mp_if: microprocessor port between a timing device and its controller
`timescale 1ns/1ps
`default_nettype none
interface rmp_mp_if;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport dev (
        input addr,
        input wr,
        input rd,
        input wdata,
        output rdata
    );
    modport ctl (
        output addr,
        output wr,
        output rd,
        output wdata,
        input rdata
    );
endinterface
`default_nettype wire

// [verilog/rmp_pkg.sv]
// rmp_pkg: constants, types and helpers shared by both ends of the protection pair
`default_nettype none
package rmp_pkg;
    // timing
    localparam int CLK_HZ = 100_000_000;
    localparam int FRAME_HZ = 8000;
    localparam int FRAME_CYC = CLK_HZ / FRAME_HZ;
    localparam int MF_FRAMES = 4;
    // two sync flops plus the edge flop before the counter reloads
    localparam int SYNC_LAT = 3;
    localparam int SELW = 3;
    // device register map on the microprocessor port
    localparam logic [7:0] A_SRC = 8'h30;
    localparam logic [7:0] A_REMOTE = 8'h31;
    localparam logic [7:0] A_STAT = 8'h32;
    localparam logic [7:0] A_BITS = 8'h33;
    localparam logic [7:0] A_MODE = 8'h34;
    localparam logic [7:0] A_CMD = 8'h35;
    localparam int MODE_MASTER = 1;
    localparam int MODE_EXTSYNC = 3;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] REMOTE_RST = 8'hFF;
    localparam logic [7:0] BITS_RST = 8'h00;
    localparam int CMD_SWBACK = 0;
    localparam int CMD_SUB = 1;
    localparam int ST_ACTIVE = 7;
    localparam int ST_HOLD = 6;
    localparam int ST_ALIGN = 5;
    localparam int ST_TABLE = 4;
    // controller APB map
    localparam logic [11:0] P_CTL = 12'h000;
    localparam logic [11:0] P_MODE = 12'h004;
    localparam logic [11:0] P_STAT = 12'h008;
    localparam int CTL_MIRROR = 0;
    localparam int CTL_SWBACK = 1;
    localparam int CTL_SUB = 2;
    localparam int STAT_BUSY = 16;

    typedef enum logic [2:0] {DS_FREE, DS_LOCKED, DS_TRACK, DS_HOLD, DS_SUB} rmp_dstate_t;
    typedef enum logic [3:0] {
        CS_IDLE, CS_RS_W, CS_RS_C, CS_RB, CS_RB_W, CS_RB_C
    } rmp_cstate_t;

    // lowest set index wins; bit 3 flags that one was found
    function automatic logic [3:0] rmp_pick(input logic [7:0] m);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (m[i]) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction
endpackage
`default_nettype wire
